// ==== logic/hsu_pkg.sv ====
package hsu_pkg;
	localparam int unsigned LEVEL_W = 7;

	// byte addresses of the register words
	localparam logic [31:0] IIR_ADDR   = 32'h4001_4008;
	localparam logic [31:0] CTRL_ADDR  = 32'h4001_400c;
	localparam logic [31:0] TRIG_ADDR  = 32'h4001_4010;

	// irq_identification bit positions
	localparam int unsigned IIR_TX      = 0;
	localparam int unsigned IIR_RXLVL   = 1;
	localparam int unsigned IIR_RXIDLE  = 2;
	localparam int unsigned IIR_FE      = 3;
	localparam int unsigned IIR_BRK     = 4;
	localparam int unsigned IIR_OE      = 5;
	localparam int unsigned IIR_TXSET   = 6;

	// uart_control fields
	localparam int unsigned CTRL_IDLE_LSB = 16;
	localparam int unsigned CTRL_RTS_EN   = 18;
	localparam int unsigned CTRL_THR_LSB  = 19;
	localparam int unsigned CTRL_RTS_INV  = 21;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_2800;
	localparam logic [31:0] CTRL_MASK     = 32'h003f_3fff;

	// rx trigger level register
	localparam logic [LEVEL_W-1:0] TRIG_RESET = 7'h10;

	// rts thresholds in bytes
	localparam logic [LEVEL_W-1:0] THR_00 = 7'h08;
	localparam logic [LEVEL_W-1:0] THR_01 = 7'h10;
	localparam logic [LEVEL_W-1:0] THR_10 = 7'h20;
	localparam logic [LEVEL_W-1:0] THR_11 = 7'h30;

	typedef enum logic [1:0] {
		HSU_IDLE_OFF = 2'h0,
		HSU_IDLE_4   = 2'h1,
		HSU_IDLE_8   = 2'h2,
		HSU_IDLE_16  = 2'h3
	} hsu_idle_cfg_t;

	function automatic logic [LEVEL_W-1:0] hsu_thr_bytes(
		input logic [1:0] sel
	);
		unique case (sel)
			2'h0: hsu_thr_bytes = THR_00;
			2'h1: hsu_thr_bytes = THR_01;
			2'h2: hsu_thr_bytes = THR_10;
			2'h3: hsu_thr_bytes = THR_11;
		endcase
	endfunction
endpackage

// ==== logic/hsu_rts_if.sv ====
`timescale 1ns/100ps
interface hsu_rts_if;
	import hsu_pkg::*;
	logic               rts_auto_enable;
	logic               rts_invert;
	logic [1:0]         rts_threshold;
	logic [LEVEL_W-1:0] rx_level;

	modport ctl (output rts_auto_enable, output rts_invert,
		output rts_threshold, output rx_level);
	modport rts (input rts_auto_enable, input rts_invert,
		input rts_threshold, input rx_level);
endinterface

// ==== logic/hsu_rts.sv ====
`timescale 1ns/100ps
module hsu_rts (
	input  wire logic pclk,
	input  wire logic presetn,
	hsu_rts_if.rts    cfg,
	output logic      rts_pin_o,
	output logic      rts_pin_oe
);
	import hsu_pkg::*;

	logic rts_q;
	logic rts_d;
	logic oe_q;
	logic oe_d;
	logic full;

	always_comb begin
		// low once the fifo passes the chosen level
		full  = cfg.rx_level > hsu_thr_bytes(cfg.rts_threshold);
		rts_d = ~full ^ cfg.rts_invert;
		oe_d  = cfg.rts_auto_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			rts_q <= rts_d;
			oe_q  <= oe_d;
		end
	end

	assign rts_pin_o  = rts_q;
	assign rts_pin_oe = oe_q;
endmodule // hsu_rts

// ==== logic/hsu_top.sv ====
`timescale 1ns/100ps
// Operation
// - idle flag sets only if enabled; rx read clears
// - level flag high while fifo above trigger
// - tx flag reports irq; tx write clears
// - writing 1 to bit 0 clears tx flag
// - control bit selects rts polarity
// - threshold field picks 8/16/32/48 bytes
// - rts low when fifo exceeds threshold
// - bit 18 enables automatic rts
// - disabled rts leaves pin undriven
// - idle config off or 4/8/16 characters
module hsu_top #(
	parameter int unsigned LW = hsu_pkg::LEVEL_W
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [hsu_pkg::LEVEL_W-1:0] rx_level,
	input  wire logic                      rx_pop,
	input  wire logic                      tx_push,
	input  wire logic                      tx_event,
	input  wire logic                      rx_idle_hit,
	input  wire logic                      rx_overrun,
	input  wire logic                      rx_break,
	input  wire logic                      rx_frame_err,
	output hsu_pkg::hsu_idle_cfg_t         rx_idle_config,
	output logic                           rts_pin_o,
	output logic                           rts_pin_oe,
	output logic                           uart_irq
);
	import hsu_pkg::*;

	// the level compare and the reset value assume the package width
	if (LW != LEVEL_W) begin : g_lw_check
		$error("hsu_top: LW must equal package LEVEL_W");
	end

	hsu_rts_if rif ();

	logic [31:0]    ctrl_q;
	logic [31:0]    ctrl_d;
	logic [LW-1:0]  trig_q;
	logic [LW-1:0]  trig_d;
	logic           tx_q;
	logic           tx_d;
	logic           lvl_q;
	logic           lvl_d;
	logic           idle_q;
	logic           idle_d;
	logic [2:0]     err_q;
	logic [2:0]     err_d;
	logic [31:0]    rdata_q;
	logic [31:0]    rdata_d;
	logic           irq_q;
	logic           irq_d;
	logic           acc;
	logic           wr;
	logic           rd;
	logic           hit_iir;
	logic           hit_ctrl;
	logic           hit_trig;
	logic           w_iir;
	hsu_idle_cfg_t  idle_cfg;

	// slave never stalls; one access cycle per transfer
	assign pready  = 1'b1;
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign rd      = acc & ~pwrite;
	assign hit_iir  = paddr == IIR_ADDR;
	assign hit_ctrl = paddr == CTRL_ADDR;
	assign hit_trig = paddr == TRIG_ADDR;
	assign pslverr = acc & ~(hit_iir | hit_ctrl | hit_trig);
	assign w_iir   = wr & hit_iir;
	assign idle_cfg = hsu_idle_cfg_t'(ctrl_q[CTRL_IDLE_LSB +: 2]);

	// configuration word written by software
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr && hit_ctrl)
			ctrl_d = pwdata & CTRL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_comb begin
		trig_d = trig_q;
		if (wr && hit_trig)
			trig_d = pwdata[LW-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q <= TRIG_RESET;
		end else begin
			trig_q <= trig_d;
		end
	end

	// set beats clear, so a forced interrupt is never lost
	always_comb begin
		tx_d = tx_q;
		if (tx_push || (w_iir && pwdata[IIR_TX]))
			tx_d = 1'b0;
		if (tx_event || (w_iir && pwdata[IIR_TXSET]))
			tx_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
		end
	end

	// no memory here: draining the fifo or raising the trigger clears it
	always_comb begin
		lvl_d = rx_level > trig_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	always_comb begin
		idle_d = idle_q;
		if (rx_pop)
			idle_d = 1'b0;
		if (rx_idle_hit && idle_cfg != HSU_IDLE_OFF)
			idle_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
		end
	end

	// write one to clear; a new error in the same cycle stays set
	always_comb begin
		err_d = err_q;
		if (w_iir)
			err_d = err_q & ~pwdata[IIR_OE:IIR_FE];
		err_d = err_d | {rx_overrun, rx_break, rx_frame_err};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 3'h0;
		end else begin
			err_q <= err_d;
		end
	end

	// registered so the request line cannot glitch
	always_comb begin
		irq_d = tx_q | lvl_q | idle_q | (|err_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// latched in setup, held through access
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			if (hit_iir)
				rdata_d = {26'h000_0000, err_q, idle_q, lvl_q, tx_q};
			else if (hit_ctrl)
				rdata_d = ctrl_q;
			else if (hit_trig)
				rdata_d = {{(32-LW){1'b0}}, trig_q};
		end else if (rd) begin
			rdata_d = rdata_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata         = rdata_q;
	assign uart_irq       = irq_q;
	assign rx_idle_config = idle_cfg;

	assign rif.rts_auto_enable = ctrl_q[CTRL_RTS_EN];
	assign rif.rts_invert      = ctrl_q[CTRL_RTS_INV];
	assign rif.rts_threshold   = ctrl_q[CTRL_THR_LSB +: 2];
	assign rif.rx_level        = rx_level;

	hsu_rts u_rts (
		.pclk       (pclk),
		.presetn    (presetn),
		.cfg        (rif.rts),
		.rts_pin_o  (rts_pin_o),
		.rts_pin_oe (rts_pin_oe)
	);
endmodule // hsu_top

// ==== dv/hsu_top_assertions.sv ====
`timescale 1ns/100ps
module hsu_top_assertions
	import hsu_pkg::*;
(
	input logic               pclk,
	input logic               presetn,
	input logic               psel,
	input logic               penable,
	input logic               pwrite,
	input logic [31:0]        paddr,
	input logic [31:0]        pwdata,
	input logic [31:0]        prdata,
	input logic [LEVEL_W-1:0] rx_level,
	input logic               rx_pop,
	input logic               tx_push,
	input logic               tx_event,
	input logic               rx_idle_hit,
	input hsu_idle_cfg_t      rx_idle_config,
	input logic               rts_pin_o,
	input logic               rts_pin_oe,
	input logic               uart_irq
);
	logic [31:0]        sh_q, sh_d;
	logic [LEVEL_W-1:0] tr_q, tr_d;
	logic               tx_m_q, tx_m_d, id_m_q, id_m_d;
	wire wr = psel && penable && pwrite;
	wire rdi = psel && penable && !pwrite && paddr == IIR_ADDR;
	wire iw = wr && paddr == IIR_ADDR;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	function automatic logic [6:0] th(logic [1:0] s);
		return s == 2'h3 ? 7'h30 : 7'h08 << s;
	endfunction
	// shadow of the writable fields, so pin checks need no hierarchy
	always_comb begin
		sh_d = sh_q;
		tr_d = tr_q;
		if (wr && paddr == CTRL_ADDR)
			sh_d = pwdata & CTRL_MASK;
		if (wr && paddr == TRIG_ADDR)
			tr_d = pwdata[LEVEL_W-1:0];
		// flag models: set beats clear
		tx_m_d = tx_m_q;
		if (tx_push || (iw && pwdata[IIR_TX]))
			tx_m_d = 1'b0;
		if (tx_event || (iw && pwdata[IIR_TXSET]))
			tx_m_d = 1'b1;
		id_m_d = id_m_q;
		if (rx_pop)
			id_m_d = 1'b0;
		if (rx_idle_hit && sh_q[17:16] != 2'h0)
			id_m_d = 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q   <= CTRL_RESET;
			tr_q   <= TRIG_RESET;
			tx_m_q <= 1'b0;
			id_m_q <= 1'b0;
		end else begin
			sh_q   <= sh_d;
			tr_q   <= tr_d;
			tx_m_q <= tx_m_d;
			id_m_q <= id_m_d;
		end
	end
	chk_rts_level: assert property (
		$past(presetn, 2) |-> rts_pin_o ==
		(($past(rx_level) <= th($past(sh_q[20:19]))) ^ $past(sh_q[21])))
		else $error("rts level wrong");
	chk_rts_drive: assert property ($past(presetn, 2) |->
		rts_pin_oe == $past(sh_q[18])) else $error("rts drive wrong");
	chk_idle_cfg: assert property (rx_idle_config == sh_q[17:16])
		else $error("idle config wrong");
	chk_tx_irq: assert property (tx_event |-> ##2 uart_irq)
		else $error("no irq after tx event");
	chk_idle_irq: assert property (rx_idle_hit &&
		rx_idle_config != HSU_IDLE_OFF |-> ##2 uart_irq) else $error("no irq");
	chk_lvl_read: assert property (rdi |-> prdata[IIR_RXLVL] ==
		($past(rx_level, 2) > $past(tr_q, 2))) else $error("level flag wrong");
	chk_push_clear: assert property (rdi |->
		prdata[IIR_TX] == $past(tx_m_q)) else $error("tx flag wrong");
	chk_pop_clear: assert property (rdi |->
		prdata[IIR_RXIDLE] == $past(id_m_q)) else $error("idle flag wrong");
	cover property (rdi && prdata[IIR_TX]);
	cover property (rdi && prdata[IIR_RXIDLE]);
	cover property (rts_pin_oe && !rts_pin_o);
endmodule // hsu_top_assertions

// ==== dv/hsu_rts_peer.sv ====
`timescale 1ns/100ps
module hsu_rts_peer (
	input  logic rts_line,
	output logic send_ok
);
	// far end only sends while the line is high
	assign send_ok = rts_line;
endmodule // hsu_rts_peer

// ==== dv/hs_uart_irq_flags_rts_flow_tb.sv ====
`timescale 1ns/100ps
module hs_uart_irq_flags_rts_flow_tb;
	import hsu_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic          uart_irq, rts_pin_o, rts_pin_oe, send_ok;
	logic [31:0]   paddr, pwdata, prdata, rd;
	logic [6:0]    lvl, ev;
	logic [40:0]   rows [10];
	hsu_idle_cfg_t cfg;
	int            miscompares, compares, n;
	// released pin is pulled high by the pin block
	wire rts_line = rts_pin_oe ? rts_pin_o : 1'b1;
	hsu_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_level(lvl), .rx_pop(ev[3]),
		.tx_push(ev[5]), .tx_event(ev[6]), .rx_idle_hit(ev[4]),
		.rx_overrun(ev[2]), .rx_break(ev[1]), .rx_frame_err(ev[0]),
		.rx_idle_config(cfg), .rts_pin_o, .rts_pin_oe, .uart_irq);
	hsu_rts_peer peer (.rts_line, .send_ok);
	task chk(input string s, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] a, d = 0);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			end_sim;
		end else begin
			// taken at the edge where pready is seen high
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task pulse(input logic [6:0] v);
		@(posedge pclk);
		ev <= v;
		@(posedge pclk);
		ev <= 0;
	endtask
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		rows = '{{32'h0004_0000, 7'h08, 2'h3}, {32'h0004_0000, 7'h09, 2'h1},
			{32'h000c_0000, 7'h10, 2'h3}, {32'h000c_0000, 7'h11, 2'h1},
			{32'h0014_0000, 7'h21, 2'h1}, {32'h001c_0000, 7'h30, 2'h3},
			{32'h003c_0000, 7'h31, 2'h3}, {32'h0020_0000, 7'h00, 2'h0},
			{32'h0002_0000, 7'h00, 2'h2}, {32'h0003_0000, 7'h00, 2'h2}};
		{presetn, psel, penable, pwrite, paddr, pwdata, lvl, ev} = 0;
		{miscompares, compares} = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, CTRL_ADDR);
		chk("ctrl reset", CTRL_RESET, rd);
		apb(0, TRIG_ADDR);
		chk("trig reset", 32'(TRIG_RESET), rd);
		chk("slverr", 0, er);
		foreach (rows[i]) begin
			apb(1, CTRL_ADDR, rows[i][40:9]);
			lvl <= rows[i][8:2];
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			chk("rts", rows[i][1], rts_pin_o);
			chk("oe", rows[i][0], rts_pin_oe);
			chk("peer", rows[i][0] ? rows[i][1] : 1'b1, send_ok);
			chk("cfg", rows[i][26:25], cfg);
		end
		apb(1, CTRL_ADDR, 0);
		pulse(7'h10);
		apb(0, IIR_ADDR);
		chk("idle off", 0, rd[2]);
		apb(1, CTRL_ADDR, 32'h0001_0000);
		pulse(7'h10);
		apb(0, IIR_ADDR);
		chk("idle", 1, rd[2]);
		chk("irq", 1, uart_irq);
		pulse(7'h08);
		apb(0, IIR_ADDR);
		chk("idle pop", 0, rd[2]);
		pulse(7'h40);
		apb(1, IIR_ADDR, 0);
		apb(0, IIR_ADDR);
		chk("tx w0", 1, rd[0]);
		apb(1, IIR_ADDR, 1);
		apb(0, IIR_ADDR);
		chk("tx w1", 0, rd[0]);
		pulse(7'h40);
		pulse(7'h20);
		apb(0, IIR_ADDR);
		chk("tx push", 0, rd[0]);
		lvl <= 7'h11;
		apb(0, IIR_ADDR);
		chk("lvl hi", 1, rd[1]);
		lvl <= 7'h10;
		apb(0, IIR_ADDR);
		chk("lvl eq", 0, rd[1]);
		apb(0, 32'h4001_4020);
		chk("unmapped", 1, er);
		chk("unmapped data", 0, rd);
		apb(1, TRIG_ADDR, 32'h0000_0005);
		lvl <= 7'h06;
		apb(0, IIR_ADDR);
		chk("lvl trig", 1, rd[1]);
		lvl <= 7'h00;
		apb(0, IIR_ADDR);
		chk("iir clear", 0, rd);
		chk("irq idle", 0, uart_irq);
		pulse(7'h07);
		apb(0, IIR_ADDR);
		chk("err flags", 32'h0000_0038, rd);
		chk("irq err", 1, uart_irq);
		apb(1, IIR_ADDR, 32'h0000_0038);
		apb(0, IIR_ADDR);
		chk("err clear", 0, rd);
		apb(1, IIR_ADDR, 32'h0000_0040);
		apb(0, IIR_ADDR);
		chk("tx set", 32'h0000_0001, rd);
		apb(1, CTRL_ADDR, 32'h0004_0000);
		repeat (2) @(posedge pclk);
		chk("oe pre", 1, rts_pin_oe);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk("oe rst", 0, rts_pin_oe);
		chk("irq rst", 0, uart_irq);
		apb(0, CTRL_ADDR);
		chk("ctrl rst", CTRL_RESET, rd);
		apb(0, IIR_ADDR);
		chk("iir rst", 0, rd);
		end_sim;
	end
endmodule // hs_uart_irq_flags_rts_flow_tb
bind hsu_top hsu_top_assertions chk_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .rx_level, .rx_pop, .tx_push,
	.tx_event, .rx_idle_hit, .rx_idle_config, .rts_pin_o, .rts_pin_oe,
	.uart_irq);
